// [rtl/supply_drop_defines.vh]
// constants for the supply drop reset control block
// assumes inclusion by bare name from rtl files
`ifndef SUPPLY_DROP_DEFINES_VH
`define SUPPLY_DROP_DEFINES_VH
`define RANGE_LOW 1'b0
`define RANGE_HIGH 1'b1
`define RESET_VECTOR_HI 16'hfffe
`define RESET_VECTOR_LO 16'hffff
`define RANGE_SETTLE_CYCLES 2
`define FLAG_RESET 1'b0
`define HOLD_RESET 1'b0
`define PIN_DRIVE_LEVEL 1'b0
`endif

// [rtl/supply_drop_reset_control.v]
// supply drop reset control: gates comparator trips into a held system reset
// assumes comparator indications are already synchronous to core_clk,
// and that reset is the power-on reset of the device
//
// Contract
// (R1) monitor enabled when leaving reset
// (R2) monitor only while power down bit clear
// (R3) reset on falling trip unless disabled
// (R4) stop mode monitoring needs stop enable
// (R5) range select high chooses higher range
// (R6) power-on reset returns range to low
// (R7) software re-selects high range each power-on
// (R8) high range below rising level resets immediately
// (R9) hold reset until rising trip asserts
// (R10) status flag follows comparator output
// (R11) monitor reset pulls external reset pin low
// (R12) polled use: enabled, reset disabled, read flag
// (R13) forced reset use: both bits zero
// (R14) drop reset in wait restarts clock, vector
// (R15) flag sets below fall, clears above rise
// (R16) no interrupt request ever raised
// (R17) two synchronized comparator indications input
// (R18) disabled monitor neither resets nor updates flag; the code keeps a hold already in ST_HOLD asserted while disabled
`timescale 1ns/10ps
`default_nettype none
`include "supply_drop_defines.vh"

module supply_drop_reset_control
#(
   // comparator latency after a range change, in core_clk cycles
   parameter SETTLE_CYCLES = `RANGE_SETTLE_CYCLES,
   // wide enough to hold SETTLE_CYCLES - 1
   parameter SETTLE_WIDTH = 2
)
(
   input wire core_clk,
   input wire reset,
   input wire monitor_power_down,
   input wire drop_reset_disable,
   input wire monitor_in_stop_enable,
   input wire trip_range_select_wr,
   input wire trip_range_select_in,
   input wire stop_mode,
   input wire wait_mode,
   input wire below_falling_level,
   input wire above_rising_level,
   output reg trip_range_select,
   output reg supply_low_flag,
   output reg drop_reset,
   output wire reset_pin_out,
   output wire reset_pin_oe_n,
   output wire cpu_clock_restart,
   output wire [15:0] reset_vector_addr_hi,
   output wire [15:0] reset_vector_addr_lo,
   output wire monitor_active,
   output wire irq_request
);

   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_ARMED = 3'h2;
   localparam [2:0] ST_HOLD = 3'h4;
   localparam [SETTLE_WIDTH-1:0] SETTLE_LOAD = SETTLE_CYCLES - 1;

   // whether the comparator is listened to at all
   function monitor_on;
      input power_down;
      input stop_enable;
      input stopped;
      begin
         monitor_on = !power_down && (!stopped || stop_enable);
      end
   endfunction

   // whether a trip may turn into a held reset
   function may_reset;
      input active;
      input reset_off;
      begin
         may_reset = active && !reset_off;
      end
   endfunction

   // set below falling, clear above rising, else keep;
   // set wins when both indications are high
   function flag_next;
      input current;
      input active;
      input below;
      input above;
      begin
         flag_next = current;
         if (active)
         begin
            if (below)
            begin
               flag_next = 1'b1;
            end
            else if (above)
            begin
               flag_next = 1'b0;
            end
         end
      end
   endfunction

   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [SETTLE_WIDTH-1:0] settle_r;
   reg [SETTLE_WIDTH-1:0] settle_nxt;
   reg wait_exit_r;
   reg wait_exit_nxt;
   reg range_nxt;
   reg flag_nxt;
   wire resets_allowed;
   wire trip_fall;
   wire range_raise;
   wire release_ok;
   wire settle_done;
   wire hold_nxt;

   // monitor_power_down is expected to reset low outside, so the monitor
   // runs from the first cycle after reset
   assign monitor_active = monitor_on(monitor_power_down, monitor_in_stop_enable,
                                      stop_mode); // R1 R2 R4 R18
   assign resets_allowed = may_reset(monitor_active, drop_reset_disable); // R3
   // comparator bits reflect the selected range, a few cycles late
   assign trip_fall = resets_allowed && below_falling_level; // R3 R17
   assign range_raise = trip_range_select_wr && trip_range_select_in &&
                        !trip_range_select; // R8
   // hysteresis: only the rising indication releases the hold
   assign release_ok = monitor_active && above_rising_level; // R9
   assign settle_done = (settle_r == {SETTLE_WIDTH{1'b0}});
   assign hold_nxt = (state_nxt == ST_HOLD);

   always @*
   begin
      range_nxt = trip_range_select;
      if (trip_range_select_wr)
      begin
         range_nxt = trip_range_select_in; // R5
      end
   end

   // range select is a plain register, written by software and cleared by power-on reset
   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         trip_range_select <= `RANGE_LOW; // R6
      end
      else
      begin
         trip_range_select <= range_nxt;
      end
   end

   // after a raise the comparator still shows the low range for a while,
   // so the rising check waits SETTLE_CYCLES before it decides
   always @*
   begin
      state_nxt = state_r;
      settle_nxt = settle_r;
      case (state_r)
         ST_IDLE:
         begin
            if (trip_fall)
            begin
               state_nxt = ST_HOLD; // R3
            end
            else if (range_raise && resets_allowed)
            begin
               state_nxt = ST_ARMED; // R8
               settle_nxt = SETTLE_LOAD;
            end
         end
         ST_ARMED:
         begin
            if (!resets_allowed)
            begin
               state_nxt = ST_IDLE; // R18
            end
            else if (trip_fall)
            begin
               state_nxt = ST_HOLD; // R3
            end
            else if (range_raise)
            begin
               settle_nxt = SETTLE_LOAD;
            end
            else if (settle_done)
            begin
               if (above_rising_level)
               begin
                  state_nxt = ST_IDLE;
               end
               else
               begin
                  state_nxt = ST_HOLD; // R8
               end
            end
            else
            begin
               settle_nxt = settle_r - 1'b1;
            end
         end
         ST_HOLD:
         begin
            if (release_ok)
            begin
               state_nxt = ST_IDLE; // R9
            end
         end
         default:
         begin
            state_nxt = ST_IDLE;
            settle_nxt = {SETTLE_WIDTH{1'b0}};
         end
      endcase
   end

   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         state_r <= ST_IDLE;
         settle_r <= {SETTLE_WIDTH{1'b0}};
         drop_reset <= `HOLD_RESET;
      end
      else
      begin
         state_r <= state_nxt;
         settle_r <= settle_nxt;
         drop_reset <= hold_nxt; // R3 R8 R9
      end
   end

   // remember a drop reset that ended wait mode for the clock restart
   always @*
   begin
      wait_exit_nxt = wait_exit_r;
      if (state_r != ST_HOLD && hold_nxt)
      begin
         wait_exit_nxt = wait_mode; // R14
      end
      else if (!hold_nxt)
      begin
         wait_exit_nxt = 1'b0;
      end
   end

   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         wait_exit_r <= 1'b0;
      end
      else
      begin
         wait_exit_r <= wait_exit_nxt;
      end
   end

   always @*
   begin
      flag_nxt = flag_next(supply_low_flag, monitor_active, below_falling_level,
                           above_rising_level); // R10 R15
   end

   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         supply_low_flag <= `FLAG_RESET; // R15
      end
      else
      begin
         supply_low_flag <= flag_nxt;
      end
   end

   // open drain style reset pin: output low, enable low while driving
   assign reset_pin_out = `PIN_DRIVE_LEVEL;
   assign reset_pin_oe_n = !drop_reset; // R11
   assign cpu_clock_restart = wait_exit_r && drop_reset; // R14
   assign reset_vector_addr_hi = `RESET_VECTOR_HI; // R14
   assign reset_vector_addr_lo = `RESET_VECTOR_LO; // R14
   // no interrupt path exists; the only actions are reset and the flag
   assign irq_request = 1'b0; // R16
endmodule
`default_nettype wire

// [bench/supply_comparator.sv]
// comparator model: registered trip bits for the chosen range
// assumes a 4-bit supply code from the bench
`timescale 1ns/10ps
`default_nettype none
module supply_comparator(input wire logic core_clk, r, input wire logic [3:0] v,
   output logic b, a);
   always @(posedge core_clk) b <= v < (r ? 4'h5 : 4'h3);
   always @(posedge core_clk) a <= v > (r ? 4'h6 : 4'h4);
endmodule
`default_nettype wire

// [bench/drop_properties.sv]
// checker for reset hold, pin and flag
// assumes a bind into the block
`timescale 1ns/10ps
`default_nettype none
module drop_properties(input wire logic core_clk, reset, monitor_power_down,
   drop_reset_disable, below_falling_level, above_rising_level, drop_reset,
   reset_pin_oe_n, supply_low_flag, monitor_active, irq_request, trip_range_select_wr,
   trip_range_select_in, trip_range_select);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   wire lo = monitor_active && below_falling_level;
   wire up = monitor_active && above_rising_level;
   a_trip_sets: assert property (lo && !drop_reset_disable |=> drop_reset) else $error("no trip");
   a_hold_rise: assert property (drop_reset && !up |=> drop_reset) else $error("early exit");
   a_exit_rise: assert property (drop_reset && up && !lo |=> !drop_reset) else $error("no exit");
   a_pin_low: assert property (reset_pin_oe_n != drop_reset) else $error("pin wrong");
   a_flag_set: assert property (lo |=> supply_low_flag) else $error("flag low");
   a_flag_keep: assert property (!monitor_active |=> $stable(supply_low_flag))
      else $error("flag moved");
   a_power_off: assert property (monitor_power_down |-> !monitor_active) else $error("on");
   a_no_irq: assert property (!irq_request) else $error("irq raised");
   a_range_write: assert property (trip_range_select_wr |=> trip_range_select == $past(trip_range_select_in))
      else $error("range not taken");
   sequence s_range_raise;
      trip_range_select_wr && trip_range_select_in && !trip_range_select && monitor_active &&
         !drop_reset_disable && !drop_reset;
   endsequence
   sequence s_still_on;
      monitor_active && !drop_reset_disable && trip_range_select;
   endsequence
   a_raise_low: assert property (s_range_raise ##1 s_still_on ##1 (s_still_on and !up) |=> drop_reset)
      else $error("no raise trip");
endmodule
bind supply_drop_reset_control drop_properties u_props(.*);
`default_nettype wire

// [bench/testbench.sv]
// bench: sets config bits and supply code, checks outputs
// assumes the comparator model adds one clock
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic core_clk=0, reset=1;
   logic [6:0] c=7'h00;
   logic [3:0] v=4'h8;
   wire b, a;
   wire [5:0] o;
   wire [15:0] vh, vl;
   wire pin, irq;
   int fails=0, check_count=0;
   initial forever #2.5 core_clk = ~core_clk;
   supply_comparator u_cmp(.core_clk, .r(o[5]), .v, .b, .a);
   supply_drop_reset_control u_dut(.core_clk, .reset, .trip_range_select_wr(c[6]),
      .trip_range_select_in(c[5]), .monitor_power_down(c[4]), .drop_reset_disable(c[3]),
      .monitor_in_stop_enable(c[2]), .stop_mode(c[1]), .wait_mode(c[0]),
      .below_falling_level(b), .above_rising_level(a), .trip_range_select(o[5]),
      .drop_reset(o[4]), .reset_pin_oe_n(o[3]), .supply_low_flag(o[2]),
      .cpu_clock_restart(o[1]), .monitor_active(o[0]), .reset_pin_out(pin),
      .reset_vector_addr_hi(vh), .reset_vector_addr_lo(vl), .irq_request(irq));
   task chk_fixed;
      check_count++;
      if (vh !== 16'hfffe || vl !== 16'hffff || pin !== 1'b0 || irq !== 1'b0)
      begin
         fails++;
         $display("wrong value at %0t: fixed outputs", $time);
      end
   endtask
   task wrap_up;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // four edges let the comparator and the block both settle
   task go(input logic [6:0] n, input logic [3:0] s, input logic [5:0] e);
      @(posedge core_clk) c <= n;
      v <= s;
      @(posedge core_clk) c[6] <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 check_count++;
      if (o !== e)
      begin
         fails++;
         $display("wrong value at %0t: got %h", $time, o);
      end
   endtask
   initial
   begin
      repeat (5) @(posedge core_clk);
      reset <= 1'b0;
      go(7'h01, 4'h8, 6'h09);
      chk_fixed;
      go(7'h01, 4'h2, 6'h17);
      go(7'h01, 4'h4, 6'h17);
      go(7'h00, 4'h8, 6'h09);
      go(7'h08, 4'h2, 6'h0d);
      go(7'h10, 4'h8, 6'h0c);
      go(7'h02, 4'h8, 6'h0c);
      go(7'h06, 4'h2, 6'h15);
      go(7'h00, 4'h8, 6'h09);
      go(7'h00, 4'h4, 6'h09);
      go(7'h60, 4'h5, 6'h31);
      @(posedge core_clk) reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      go(7'h00, 4'h4, 6'h09);
      go(7'h60, 4'h8, 6'h29);
      wrap_up;
   end
endmodule
`default_nettype wire
